// ### src/shutoff_regs.svh
// constants of the shutoff state logic: times, cycle counts, command codes, register map
// assumes a 20 MHz pclk; included by both ends, the checker and the bench
`ifndef SHUTOFF_REGS_SVH
`define SHUTOFF_REGS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 20000000
`define GLITCH_TIME_US 500
`define GLITCH_CYC (((`CLK_HZ / 1000) * `GLITCH_TIME_US + 999) / 1000)
`define SKEW_TIME_MS 10000
`define SKEW_CYC ((`CLK_HZ / 1000) * `SKEW_TIME_MS)
`define POWER_OFF_TIME_MS 20
`define POWER_OFF_CYC ((`CLK_HZ / 1000) * `POWER_OFF_TIME_MS)

// ****************************************************************
// command codes on the link
// ****************************************************************
`define CMD_ALARM_CLEAR 8'h06
`define CMD_STATUS_MONITOR 8'h30
`define CMD_POWER_ON 8'h31
`define CMD_POWER_OFF 8'h32
`define CMD_INTERPOLATION 8'h34
`define CMD_POSITIONING 8'h35
`define CMD_CONST_FEED 8'h36
`define CMD_LATCH_INTERP 8'h38
`define CMD_EXT_POSITIONING 8'h39
`define CMD_HOMING 8'h3A

// ****************************************************************
// io monitor field
// ****************************************************************
`define IOMON_HBB_BIT 10

// ****************************************************************
// host register map (byte offsets) and fields
// ****************************************************************
`define REG_CMD 12'h000
`define REG_STATUS 12'h004
`define REG_CTRL 12'h008
`define REG_IOMON 12'h00C
`define ST_POWER_ON_BIT 0
`define ST_HARDWIRED_BLOCK_STATE_BIT 1
`define ST_WARNING_BIT 2
`define ST_SKEW_BIT 3
`define ST_UTIL_LOCK_BIT 4
`define ST_PENDING_BIT 5
`define ST_DONE_BIT 6
`define ST_OK_BIT 7
`define CTRL_UTIL_BIT 0
`define CTRL_RESET 32'h0000_0000

`endif

// ### src/shutoff_pkg.sv
// types shared by both ends of the shutoff link
// assumes shutoff_regs.svh for all numbers
package shutoff_pkg;
   typedef enum logic [1:0] {ST_BLOCKED, ST_POWERED, ST_HARDWIRED_BLOCK_STATE} drive_state_t;
   typedef logic [7:0] cmd_code_t;
endpackage

// ### src/shutoff_link.sv
// link between host motion controller and drive shutoff logic
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface shutoff_link;
   import shutoff_pkg::*;
   logic cmd_valid;
   cmd_code_t cmd_code;
   logic util_active;
   logic cmd_done;
   logic cmd_ok;
   logic power_on_flag;
   logic [15:0] io_monitor;
   logic cmd_warning;
   logic skew_alarm;
   logic util_lock;

   modport dev
   (
      input cmd_valid, cmd_code, util_active,
      output cmd_done, cmd_ok, power_on_flag, io_monitor, cmd_warning, skew_alarm, util_lock
   );
   modport host
   (
      output cmd_valid, cmd_code, util_active,
      input cmd_done, cmd_ok, power_on_flag, io_monitor, cmd_warning, skew_alarm, util_lock
   );
endinterface

// ### src/shutoff_device.sv
// drive end: shutoff channel filtering, block state machine, command acceptance, outputs
// assumes channel inputs synchronous to pclk, 1 = ON (current flowing); commands come over shutoff_link
`timescale 1ns/1ps
`include "shutoff_regs.svh"

// How it works
// - either channel OFF enters hardwired block
// - block state: monitor bit set, power flag clear
// - after power-off, both OFF sits in block
// - both ON again: blocked state, power-on accepted
// - power-on while OFF keeps block state
// - host sends power-off then power-on to leave
// - block kept without main power until power-off; here exit ignores main power: both ON and no retained power-on
// - block during executing command raises warning
// - alarm clear returns to normal status
// - host should stop motion before shutoff
// - one channel OFF 10 s raises skew alarm
// - both OFF removes motor power within 20 ms
// - OFF pulses of 0.5 ms or less ignored
// - utilities interrupted by shutoff need restart
// - block state refuses power-on, ready held off
// - ready only when blocked, unpowered, both ON
// - block drops brake release without delay
// - dynamic brake on block when selected
// - block state alone never raises fault
// - safety circuit drives both channels redundantly
// - monitor output high only when both OFF
module shutoff_device
   import shutoff_pkg::*;
#(
   parameter int GLITCH_CYC = `GLITCH_CYC,
   parameter int SKEW_CYC = `SKEW_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic shutoff_input_a,
   input wire logic shutoff_input_b,
   input wire logic main_power_on,
   input wire logic stop_method_select,
   input wire logic [15:0] brake_delay_setting,
   input wire logic motion_done,
   shutoff_link.dev link,
   output logic motor_power_en,
   output logic drive_ready,
   output logic brake_release_output,
   output logic fault_output,
   output logic shutoff_monitor_output,
   output logic dynamic_brake_en
);

   localparam int GW = $clog2(GLITCH_CYC + 2);
   localparam int SW = $clog2(SKEW_CYC + 1);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   generate
      if (GLITCH_CYC < 1 || SKEW_CYC < 2 || GLITCH_CYC + 2 > `POWER_OFF_CYC)
      begin : g_bad
         $error("shutoff_device: timing parameters out of range");
      end
   endgenerate

   // ****************************************************************
   // channel glitch filters
   // ****************************************************************
   logic [1:0] chan_on;
   logic [1:0] off_q;
   assign chan_on = {shutoff_input_b, shutoff_input_a};

   // an OFF counts only once it has lasted longer than the glitch time
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_filt
         logic [GW-1:0] cnt_q;
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cnt_q <= '0;
               off_q[gi] <= 1'b0;
            end
            else if (chan_on[gi])
            begin
               cnt_q <= '0; // ON is taken at once
               off_q[gi] <= 1'b0;
            end
            else if (cnt_q == GW'(GLITCH_CYC))
               off_q[gi] <= 1'b1; // OFF beyond 0.5 ms recognised
            else
               cnt_q <= cnt_q + GW'(1);
         end
      end
   endgenerate

   logic any_off;
   logic both_off;
   assign any_off = off_q[0] | off_q[1];
   assign both_off = off_q[0] & off_q[1];

   // ****************************************************************
   // command decode
   // ****************************************************************
   drive_state_t state_q;
   logic retain_q;
   logic motion_q;
   logic warn_q;
   logic skew_q;
   logic util_lock_q;
   logic [15:0] hold_q;
   logic power_q;
   logic is_on;
   logic is_off;
   logic is_clr;
   logic is_motion;
   logic on_ok;
   logic cmd_ok;
   logic enter_hardwired_block_state;

   assign is_on = link.cmd_valid && link.cmd_code == `CMD_POWER_ON;
   assign is_off = link.cmd_valid && link.cmd_code == `CMD_POWER_OFF;
   assign is_clr = link.cmd_valid && link.cmd_code == `CMD_ALARM_CLEAR;
   assign is_motion = link.cmd_valid && (link.cmd_code == `CMD_INTERPOLATION
      || link.cmd_code == `CMD_POSITIONING || link.cmd_code == `CMD_CONST_FEED
      || link.cmd_code == `CMD_LATCH_INTERP || link.cmd_code == `CMD_EXT_POSITIONING
      || link.cmd_code == `CMD_HOMING);
   // power-on only from the blocked state with both channels ON
   assign on_ok = state_q == ST_BLOCKED && !any_off && !skew_q && !util_lock_q && !power_q;
   assign enter_hardwired_block_state = any_off && state_q != ST_HARDWIRED_BLOCK_STATE;

   // acceptance answer for every command
   always_comb
   begin
      cmd_ok = 1'b0;
      if (is_on)
         cmd_ok = on_ok;
      else if (is_off || is_clr)
         cmd_ok = 1'b1;
      else if (is_motion)
         cmd_ok = state_q == ST_POWERED && !any_off;
      else if (link.cmd_valid)
         cmd_ok = link.cmd_code == `CMD_STATUS_MONITOR;
   end

   // ****************************************************************
   // block state machine
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= ST_BLOCKED;
      else
      begin
         unique case (state_q)
            ST_BLOCKED:
            begin
               if (any_off)
                  state_q <= ST_HARDWIRED_BLOCK_STATE;
               else if (is_on && on_ok)
                  state_q <= ST_POWERED;
            end
            ST_POWERED:
            begin
               if (any_off)
                  state_q <= ST_HARDWIRED_BLOCK_STATE;
               else if (is_off || !main_power_on)
                  state_q <= ST_BLOCKED;
            end
            ST_HARDWIRED_BLOCK_STATE:
            begin
               // leaves only with both ON and no retained power-on request
               if (!any_off && !retain_q && !is_on)
                  state_q <= ST_BLOCKED;
            end
         endcase
      end
   end

   // power-on refused in block state is remembered until power-off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         retain_q <= 1'b0;
      else if (is_on && (state_q == ST_HARDWIRED_BLOCK_STATE || enter_hardwired_block_state))
         retain_q <= 1'b1;
      else if (is_off)
         retain_q <= 1'b0;
   end

   // tracks an action command still executing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         motion_q <= 1'b0;
      else if (is_motion && cmd_ok)
         motion_q <= 1'b1;
      else if (motion_done || state_q != ST_POWERED)
         motion_q <= 1'b0;
   end

   // ****************************************************************
   // warning and skew alarm
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         warn_q <= 1'b0;
      else if ((enter_hardwired_block_state && (state_q == ST_POWERED || motion_q)) || (is_on && any_off))
         warn_q <= 1'b1; // set wins over clear
      else if (is_clr)
         warn_q <= 1'b0;
   end

   logic [SW-1:0] skew_cnt_q;
   logic skew_hit;
   assign skew_hit = (off_q[0] ^ off_q[1]) && skew_cnt_q == SW'(SKEW_CYC - 1);

   // counts while exactly one channel is OFF
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         skew_cnt_q <= '0;
      else if (!(off_q[0] ^ off_q[1]))
         skew_cnt_q <= '0;
      else if (!skew_hit)
         skew_cnt_q <= skew_cnt_q + SW'(1);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         skew_q <= 1'b0;
      else if (skew_hit)
         skew_q <= 1'b1;
      else if (is_clr)
         skew_q <= 1'b0; // only alarm clear ends it
   end

   // interrupted utility stays locked until the host cancels it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         util_lock_q <= 1'b0;
      else if (enter_hardwired_block_state && link.util_active)
         util_lock_q <= 1'b1;
      else if (!link.util_active)
         util_lock_q <= 1'b0;
   end

   // ****************************************************************
   // power, brake and pin outputs
   // ****************************************************************
   // power-off holds current for the brake delay; block bypasses it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold_q <= 16'h0000;
      else if (any_off || !main_power_on)
         hold_q <= 16'h0000;
      else if (state_q == ST_POWERED && is_off)
         hold_q <= brake_delay_setting;
      else if (hold_q != 16'h0000)
         hold_q <= hold_q - 16'h0001;
   end

   logic ready_q;
   logic brake_q;
   logic fault_q;
   logic monitor_q;
   logic dyn_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         power_q <= 1'b0;
         ready_q <= 1'b0;
         brake_q <= 1'b0;
         fault_q <= 1'b0;
         monitor_q <= 1'b0;
         dyn_q <= 1'b0;
      end
      else
      begin
         power_q <= !any_off && main_power_on && (state_q == ST_POWERED || hold_q != 16'h0000);
         ready_q <= state_q == ST_BLOCKED && !any_off && !power_q && !skew_q;
         brake_q <= state_q == ST_POWERED && !any_off && main_power_on && !is_off;
         fault_q <= skew_q; // block state does not drive fault
         monitor_q <= both_off;
         dyn_q <= (state_q == ST_HARDWIRED_BLOCK_STATE || enter_hardwired_block_state) && stop_method_select;
      end
   end

   assign motor_power_en = power_q;
   assign drive_ready = ready_q;
   assign brake_release_output = brake_q;
   assign fault_output = fault_q;
   assign shutoff_monitor_output = monitor_q;
   assign dynamic_brake_en = dyn_q;

   // ****************************************************************
   // link answers
   // ****************************************************************
   logic done_q;
   logic ok_q;
   logic pwr_flag_q;
   logic [15:0] iomon_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_q <= 1'b0;
         ok_q <= 1'b0;
         pwr_flag_q <= 1'b0;
         iomon_q <= 16'h0000;
      end
      else
      begin
         done_q <= link.cmd_valid;
         ok_q <= link.cmd_valid && cmd_ok;
         pwr_flag_q <= state_q == ST_POWERED;
         iomon_q <= 16'h0000;
         iomon_q[`IOMON_HBB_BIT] <= state_q == ST_HARDWIRED_BLOCK_STATE;
      end
   end

   assign link.cmd_done = done_q;
   assign link.cmd_ok = ok_q;
   assign link.power_on_flag = pwr_flag_q;
   assign link.io_monitor = iomon_q;
   assign link.cmd_warning = warn_q;
   assign link.skew_alarm = skew_q;
   assign link.util_lock = util_lock_q;

endmodule

// ### src/shutoff_host.sv
// host end: APB register slave that issues link commands and shows drive status
// assumes software on APB and one clock shared with the drive end
`timescale 1ns/1ps
`include "shutoff_regs.svh"

module shutoff_host
   import shutoff_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   shutoff_link.host link
);

   // ****************************************************************
   // apb handshake
   // ****************************************************************
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic access;
   logic commit;
   logic pending_q;
   logic done_q;
   logic ok_q;
   logic cmd_valid_q;
   cmd_code_t code_q;
   logic [31:0] ctrl_q;
   logic [31:0] status;
   logic mapped;

   assign access = psel && penable && !pready_q;
   assign commit = psel && penable && pready_q && pwrite && !pslverr_q;
   assign mapped = paddr == `REG_CMD || paddr == `REG_STATUS || paddr == `REG_CTRL || paddr == `REG_IOMON;

   // status word seen by software
   always_comb
   begin
      status = 32'h0000_0000;
      status[`ST_POWER_ON_BIT] = link.power_on_flag;
      status[`ST_HARDWIRED_BLOCK_STATE_BIT] = link.io_monitor[`IOMON_HBB_BIT];
      status[`ST_WARNING_BIT] = link.cmd_warning;
      status[`ST_SKEW_BIT] = link.skew_alarm;
      status[`ST_UTIL_LOCK_BIT] = link.util_lock;
      status[`ST_PENDING_BIT] = pending_q;
      status[`ST_DONE_BIT] = done_q;
      status[`ST_OK_BIT] = ok_q;
   end

   // one wait state, then answer with data and error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= access;
         pslverr_q <= access && (!mapped || (pwrite && paddr == `REG_CMD && pending_q)
            || (pwrite && (paddr == `REG_STATUS || paddr == `REG_IOMON)));
         if (access && !pwrite)
         begin
            unique case (paddr)
               `REG_CMD: prdata_q <= {24'h000000, code_q};
               `REG_STATUS: prdata_q <= status;
               `REG_CTRL: prdata_q <= ctrl_q;
               `REG_IOMON: prdata_q <= {16'h0000, link.io_monitor};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ****************************************************************
   // command issue
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_valid_q <= 1'b0;
         code_q <= 8'h00;
      end
      else
      begin
         cmd_valid_q <= commit && paddr == `REG_CMD;
         if (commit && paddr == `REG_CMD)
            code_q <= pwdata[7:0];
      end
   end

   // pending until the drive answers; done and ok show the last answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pending_q <= 1'b0;
         done_q <= 1'b0;
         ok_q <= 1'b0;
      end
      else if (link.cmd_done)
      begin
         pending_q <= 1'b0;
         done_q <= 1'b1;
         ok_q <= link.cmd_ok;
      end
      else if (commit && paddr == `REG_CMD)
      begin
         pending_q <= 1'b1;
         done_q <= 1'b0;
         ok_q <= 1'b0;
      end
   end

   // utility activity flag, cleared by software to cancel a utility
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= `CTRL_RESET;
      else if (commit && paddr == `REG_CTRL)
         ctrl_q <= {31'h0000_0000, pwdata[`CTRL_UTIL_BIT]};
   end

   assign link.cmd_valid = cmd_valid_q;
   assign link.cmd_code = code_q;
   assign link.util_active = ctrl_q[`CTRL_UTIL_BIT];

endmodule

// ### verif/shutoff_monitor.sv
// checker of the shutoff link and the drive outputs
// assumes one pclk domain; the bench places it beside the link
`timescale 1ns/1ps
`include "shutoff_regs.svh"
module shutoff_monitor
   import shutoff_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmd_valid,
   input wire cmd_code_t cmd_code,
   input wire logic cmd_done,
   input wire logic cmd_ok,
   input wire logic power_on_flag,
   input wire logic [15:0] io_monitor,
   input wire logic skew_alarm,
   input wire logic shutoff_input_a,
   input wire logic shutoff_input_b,
   input wire logic motor_power_en,
   input wire logic drive_ready,
   input wire logic brake_release_output,
   input wire logic fault_output,
   input wire logic shutoff_monitor_output
);
   // ****************
   // assertions
   // ****************
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // block state as the host sees it
   wire logic hbb = io_monitor[`IOMON_HBB_BIT];

   a_hbb_no_power: assert property (hbb |-> !power_on_flag)
      else $error("power flag set in block state");
   a_ready_gate: assert property (drive_ready |-> !motor_power_en && !power_on_flag && !hbb)
      else $error("ready while powered or blocked");
   a_hbb_refuse_on: assert property (cmd_valid && cmd_code == `CMD_POWER_ON && shutoff_monitor_output
      && !shutoff_input_a && !shutoff_input_b |=> cmd_done && !cmd_ok)
      else $error("power-on taken with channels off");
   a_done_next: assert property (cmd_valid |=> cmd_done)
      else $error("no answer one cycle after command");
   a_skew_held: assert property (skew_alarm && !(cmd_valid && cmd_code == `CMD_ALARM_CLEAR) |=> skew_alarm)
      else $error("skew alarm dropped without clear");
   a_fault_not_hbb: assert property (hbb && !skew_alarm && !$past(skew_alarm) |-> !fault_output)
      else $error("fault raised by block state");
   a_hbb_brake_off: assert property (hbb |-> !brake_release_output && !motor_power_en)
      else $error("brake or power on in block state");
   a_both_off_cut: assert property ((!shutoff_input_a && !shutoff_input_b) [*8]
      |-> shutoff_monitor_output && !motor_power_en)
      else $error("both off without power cut");
   a_one_off_cut: assert property ((!shutoff_input_a) [*8] |-> !motor_power_en)
      else $error("one channel off without power cut");
   a_monitor_clear: assert property ((shutoff_input_a || shutoff_input_b) [*3] |-> !shutoff_monitor_output)
      else $error("monitor high with a channel on");

   // main scenarios reached
   c_power_on: cover property (cmd_valid && cmd_code == `CMD_POWER_ON ##1 cmd_ok);
   c_block: cover property ($rose(hbb));
   c_skew: cover property ($rose(skew_alarm));
endmodule

// ### verif/test_safe_torque_off_state_logic.sv
// self-checking bench: APB host end driving the drive end over the link
// assumes GLITCH_CYC 4 and SKEW_CYC 50 to keep the run short
`timescale 1ns/1ps
`include "shutoff_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_safe_torque_off_state_logic import shutoff_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic shutoff_input_a, shutoff_input_b, main_power_on, stop_method_select, motion_done;
   logic [15:0] brake_delay_setting;
   logic motor_power_en, drive_ready, brake_release_output, fault_output, shutoff_monitor_output, dynamic_brake_en;
   int num_errors, tests_run, cyc;

   // ****************
   // design and checker
   // ****************
   shutoff_link shutoff_link_i();
   shutoff_device #(.GLITCH_CYC(4), .SKEW_CYC(50)) shutoff_device_i (.pclk, .presetn, .shutoff_input_a,
      .shutoff_input_b, .main_power_on, .stop_method_select, .brake_delay_setting, .motion_done,
      .link(shutoff_link_i), .motor_power_en, .drive_ready, .brake_release_output, .fault_output,
      .shutoff_monitor_output, .dynamic_brake_en);
   shutoff_host shutoff_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .link(shutoff_link_i));
   shutoff_monitor chk_i (.pclk, .presetn, .cmd_valid(shutoff_link_i.cmd_valid),
      .cmd_code(shutoff_link_i.cmd_code), .cmd_done(shutoff_link_i.cmd_done), .cmd_ok(shutoff_link_i.cmd_ok),
      .power_on_flag(shutoff_link_i.power_on_flag), .io_monitor(shutoff_link_i.io_monitor),
      .skew_alarm(shutoff_link_i.skew_alarm), .shutoff_input_a, .shutoff_input_b, .motor_power_en,
      .drive_ready, .brake_release_output, .fault_output, .shutoff_monitor_output);

   // ****************
   // clock, watchdog, bus tasks
   // ****************
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // a hang counts as a mismatch
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         test_done();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // issue a command, then read its verdict from status
   task automatic cmd(input logic [7:0] c, input logic ok);
      apb(1'b1, `REG_CMD, {24'h0, c});
      tick(4);
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK("cmd_ok", ok, rd[`ST_OK_BIT])
   endtask
   task automatic status(input int b, input logic e, input string n);
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK(n, e, rd[b])
   endtask
   task automatic chan(input logic a, input logic b, input int n);
      shutoff_input_a <= a;
      shutoff_input_b <= b;
      tick(n);
   endtask

   // ****************
   // scenarios
   // ****************
   // power on, every motion code, short off pulse ignored
   task automatic t_power_on;
      logic [7:0] codes [6] = '{`CMD_INTERPOLATION, `CMD_POSITIONING, `CMD_CONST_FEED, `CMD_LATCH_INTERP,
         `CMD_EXT_POSITIONING, `CMD_HOMING};
      cmd(`CMD_POWER_ON, 1'b1);
      status(`ST_POWER_ON_BIT, 1'b1, "power_on");
      `CHK("brake_on", 1'b1, brake_release_output)
      `CHK("ready_pwr", 1'b0, drive_ready)
      foreach (codes[i])
      begin
         cmd(codes[i], 1'b1);
         motion_done <= 1'b1;
         tick(1);
         motion_done <= 1'b0;
      end
      chan(1'b0, 1'b0, 4);
      chan(1'b1, 1'b1, 3);
      `CHK("glitch_pwr", 1'b1, motor_power_en)
   endtask
   // both channels off while powered
   task automatic t_block_entry;
      chan(1'b0, 1'b0, 10);
      `CHK("power_cut", 1'b0, motor_power_en)
      `CHK("brake", 1'b0, brake_release_output)
      `CHK("monitor", 1'b1, shutoff_monitor_output)
      `CHK("fault", 1'b0, fault_output)
      `CHK("dyn_brake", 1'b1, dynamic_brake_en)
      `CHK("ready_hbb", 1'b0, drive_ready)
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b1, "hbb");
      status(`ST_POWER_ON_BIT, 1'b0, "power_off");
      status(`ST_WARNING_BIT, 1'b1, "warning");
      status(`ST_UTIL_LOCK_BIT, 1'b1, "util_lock");
      cmd(`CMD_STATUS_MONITOR, 1'b1);
      apb(1'b0, `REG_IOMON, 32'h0);
      `CHK("iomon", 32'h1 << `IOMON_HBB_BIT, rd)
   endtask
   // power-on while off keeps the block state until power-off
   task automatic t_retain;
      cmd(`CMD_POWER_ON, 1'b0);
      main_power_on <= 1'b0;
      chan(1'b1, 1'b1, 10);
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b1, "hbb_kept");
      main_power_on <= 1'b1;
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b1, "hbb_main");
      apb(1'b1, `REG_CTRL, 32'h0);
      status(`ST_UTIL_LOCK_BIT, 1'b0, "util_free");
      cmd(`CMD_POWER_ON, 1'b0);
      cmd(`CMD_POWER_OFF, 1'b1);
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b0, "hbb_left");
      `CHK("ready", 1'b1, drive_ready)
      cmd(`CMD_ALARM_CLEAR, 1'b1);
      status(`ST_WARNING_BIT, 1'b0, "warn_clr");
      cmd(`CMD_POWER_ON, 1'b1);
      cmd(`CMD_POWER_OFF, 1'b1);
   endtask
   // one channel off: skew alarm after its count, latched; then orderly shutoff
   task automatic t_skew;
      chan(1'b0, 1'b1, 30);
      status(`ST_SKEW_BIT, 1'b0, "skew_early");
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b1, "hbb_one");
      tick(40);
      `CHK("fault_skew", 1'b1, fault_output)
      chan(1'b1, 1'b1, 5);
      status(`ST_SKEW_BIT, 1'b1, "skew_held");
      cmd(`CMD_ALARM_CLEAR, 1'b1);
      status(`ST_SKEW_BIT, 1'b0, "skew_clr");
      stop_method_select <= 1'b0;
      chan(1'b0, 1'b0, 10);
      `CHK("dyn_off", 1'b0, dynamic_brake_en)
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b1, "hbb_quiet");
      status(`ST_WARNING_BIT, 1'b0, "no_warn");
      chan(1'b1, 1'b1, 5);
      status(`ST_HARDWIRED_BLOCK_STATE_BIT, 1'b0, "hbb_exit");
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // reset, utility active, then the scenarios
   initial
   begin
      {presetn, psel, penable, pwrite, motion_done} = '0;
      {paddr, pwdata} = '0;
      {shutoff_input_a, shutoff_input_b, main_power_on, stop_method_select} = 4'hF;
      brake_delay_setting = 16'h0003;
      tick(3);
      presetn <= 1'b1;
      tick(2);
      apb(1'b1, `REG_CTRL, 32'h1);
      t_power_on();
      t_block_entry();
      t_retain();
      t_skew();
      apb(1'b1, 12'hFF0, 32'h0);
      `CHK("unmapped", 1'b1, err)
      test_done();
   end
endmodule
